// ### rtl/abid_pkg.sv
// constants and types shared by the instruction decode/execute block
package abid_pkg;

  localparam int PC_W = 21;
  localparam int FA_W = 12;

  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_ADDC_HI  = 6'h08;  // 0010 00
  localparam logic [5:0] OPC_ANDF_HI  = 6'h05;  // 0001 01
  localparam logic [7:0] OPC_ANDK_HI  = 8'h0B;  // 0000 1011
  localparam logic [3:0] OPC_BCLR_HI  = 4'h9;   // 1001
  localparam logic [7:0] OPC_BRC_HI   = 8'hE2;
  localparam logic [7:0] OPC_BRNC_HI  = 8'hE3;
  localparam logic [7:0] OPC_BRN_HI   = 8'hE6;
  localparam logic [7:0] OPC_BRNN_HI  = 8'hE7;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam int DEST_BIT  = 9;
  localparam int BANK_BIT  = 8;
  localparam int BPOS_LSB  = 9;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;

  // status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OVFL = 3;
  localparam int ST_N  = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [3:0] BANK_ACCESS_HI = 4'h0;
  localparam logic [3:0] BANK_ACCESS_SFR = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;

  typedef enum logic [1:0] {
    ABID_Q1 = 2'b00,
    ABID_Q2 = 2'b01,
    ABID_Q3 = 2'b11,
    ABID_Q4 = 2'b10
  } abid_phase_t;

  typedef enum logic [3:0] {
    ABID_OP_NONE,
    ABID_OP_ADDC,
    ABID_OP_ANDK,
    ABID_OP_ANDF,
    ABID_OP_BCLR,
    ABID_OP_BRC,
    ABID_OP_BRNC,
    ABID_OP_BRN,
    ABID_OP_BRNN
  } abid_op_t;

endpackage

// ### rtl/abid_alu_if.sv
// interface carrying operands and results between core and ALU
`timescale 1ns/1ps
interface abid_alu_if;
  abid_pkg::abid_op_t op;
  logic [7:0]         acc;
  logic [7:0]         opnd;
  logic [7:0]         lit;
  logic [2:0]         bpos;
  logic [4:0]         st_in;
  logic [7:0]         res;
  logic [4:0]         st_out;

  modport core (output op, output acc, output opnd, output lit, output bpos, output st_in,
                input res, input st_out);
  modport alu  (input op, input acc, input opnd, input lit, input bpos, input st_in,
                output res, output st_out);
endinterface

// ### rtl/abid_alu.sv
// combinational datapath for add-with-carry, AND and bit clear
`timescale 1ns/1ps
module abid_alu (
  abid_alu_if.alu a
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] r;
  logic [4:0] s;

  always_comb begin
    sum = {1'b0, a.acc} + {1'b0, a.opnd} + {8'h00, a.st_in[abid_pkg::ST_C]};
    nib = {1'b0, a.acc[3:0]} + {1'b0, a.opnd[3:0]} + {4'h0, a.st_in[abid_pkg::ST_C]};
    r = 8'h00;
    s = a.st_in;
    case (a.op)
      abid_pkg::ABID_OP_ADDC: begin
        r = sum[7:0];
        // only these five bits move
        s[abid_pkg::ST_C]  = sum[8];
        s[abid_pkg::ST_DIGIT] = nib[4];
        s[abid_pkg::ST_Z]  = (sum[7:0] == 8'h00);
        s[abid_pkg::ST_OVFL] = (a.acc[7] == a.opnd[7]) && (sum[7] != a.acc[7]);
        s[abid_pkg::ST_N]  = sum[7];
      end
      abid_pkg::ABID_OP_ANDK, abid_pkg::ABID_OP_ANDF: begin
        r = a.acc & ((a.op == abid_pkg::ABID_OP_ANDK) ? a.lit : a.opnd);
        s[abid_pkg::ST_Z] = (r == 8'h00);
        s[abid_pkg::ST_N] = r[7];
      end
      abid_pkg::ABID_OP_BCLR: begin
        r = a.opnd & ~(8'h01 << a.bpos);
      end
      default: begin
        r = 8'h00;
      end
    endcase
  end

  assign a.res    = r;
  assign a.st_out = s;
endmodule

// ### rtl/abid_core.sv
// four-phase decode and execute core for a subset of the instruction set
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module abid_core (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic [15:0]               instr_i,
  input  wire logic                      ext_set_en_i,
  input  wire logic [3:0]                bank_sel_i,
  input  wire logic [abid_pkg::PC_W-1:0] idx_base_i,
  input  wire logic [7:0]                file_rdata_i,
  output logic      [abid_pkg::PC_W-1:0] pc_o,
  output logic                           fetch_o,
  output logic      [abid_pkg::FA_W-1:0] file_addr_o,
  output logic                           file_rd_o,
  output logic                           file_wr_o,
  output logic      [7:0]                file_wdata_o,
  output logic      [7:0]                acc_o,
  output logic      [4:0]                status_o,
  output logic      [1:0]                phase_o,
  output logic                           flush_o,
  output logic                           illegal_o
);

  typedef struct packed {
    abid_pkg::abid_phase_t ph;
    abid_pkg::abid_op_t    op;
    logic                  nop_cyc;
    logic                  take;
    logic [15:0]           ir;
    logic [7:0]            opnd;
    logic [7:0]            res;
    logic [4:0]            st;
    logic [7:0]            acc;
    logic [abid_pkg::PC_W-1:0] pc;
    logic [abid_pkg::FA_W-1:0] fa;
    logic                  rd;
    logic                  wr;
    logic [7:0]            wd;
    logic                  illegal;
  } abid_state_t;

  abid_state_t s_q;
  abid_state_t s_d;

  abid_alu_if alu_bus ();

  abid_alu u_alu (
    .a (alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  abid_pkg::abid_op_t dec_op;
  always_comb begin
    if (instr_i[15:10] == abid_pkg::OPC_ADDC_HI) begin
      dec_op = abid_pkg::ABID_OP_ADDC;
    end else if (instr_i[15:10] == abid_pkg::OPC_ANDF_HI) begin
      dec_op = abid_pkg::ABID_OP_ANDF;
    end else if (instr_i[15:8] == abid_pkg::OPC_ANDK_HI) begin
      dec_op = abid_pkg::ABID_OP_ANDK;
    end else if (instr_i[15:12] == abid_pkg::OPC_BCLR_HI) begin
      dec_op = abid_pkg::ABID_OP_BCLR;
    end else if (instr_i[15:8] == abid_pkg::OPC_BRC_HI) begin
      dec_op = abid_pkg::ABID_OP_BRC;
    end else if (instr_i[15:8] == abid_pkg::OPC_BRNC_HI) begin
      dec_op = abid_pkg::ABID_OP_BRNC;
    end else if (instr_i[15:8] == abid_pkg::OPC_BRN_HI) begin
      dec_op = abid_pkg::ABID_OP_BRN;
    end else if (instr_i[15:8] == abid_pkg::OPC_BRNN_HI) begin
      dec_op = abid_pkg::ABID_OP_BRNN;
    end else begin
      dec_op = abid_pkg::ABID_OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // operand address: access bank, banked, or indexed literal offset
  // ----------------------------------------------------------------
  logic [abid_pkg::FA_W-1:0] dec_fa;
  logic [abid_pkg::PC_W-1:0] idx_sum;
  always_comb begin
    idx_sum = idx_base_i + {13'h0000, instr_i[7:0]};
    if (!instr_i[abid_pkg::BANK_BIT] && ext_set_en_i && (instr_i[7:0] <= abid_pkg::INDEXED_LIMIT)) begin
      dec_fa = idx_sum[abid_pkg::FA_W-1:0];
    end else if (instr_i[abid_pkg::BANK_BIT]) begin
      dec_fa = {bank_sel_i, instr_i[7:0]};
    end else if (instr_i[7:0] < abid_pkg::ACCESS_SPLIT) begin
      dec_fa = {abid_pkg::BANK_ACCESS_HI, instr_i[7:0]};
    end else begin
      dec_fa = {abid_pkg::BANK_ACCESS_SFR, instr_i[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // branch condition and target
  // ----------------------------------------------------------------
  logic                      cond;
  logic [abid_pkg::PC_W-1:0] offs;
  logic [abid_pkg::PC_W-1:0] target;
  always_comb begin
    case (s_q.op)
      abid_pkg::ABID_OP_BRC:  cond = s_q.st[abid_pkg::ST_C];
      abid_pkg::ABID_OP_BRNC: cond = !s_q.st[abid_pkg::ST_C];
      abid_pkg::ABID_OP_BRN:  cond = s_q.st[abid_pkg::ST_N];
      abid_pkg::ABID_OP_BRNN: cond = !s_q.st[abid_pkg::ST_N];
      default:                cond = 1'b0;
    endcase
    // signed 8-bit n, sign extended then doubled
    offs   = {{(abid_pkg::PC_W-9){s_q.ir[7]}}, s_q.ir[7:0], 1'b0};
    // pc already holds branch address + 2 after fetch
    target = s_q.pc + offs;
  end

  logic is_branch;
  logic writes_file;
  assign is_branch = (s_q.op == abid_pkg::ABID_OP_BRC) || (s_q.op == abid_pkg::ABID_OP_BRNC) ||
                     (s_q.op == abid_pkg::ABID_OP_BRN) || (s_q.op == abid_pkg::ABID_OP_BRNN);
  assign writes_file = (s_q.op == abid_pkg::ABID_OP_BCLR) ||
                       (((s_q.op == abid_pkg::ABID_OP_ADDC) || (s_q.op == abid_pkg::ABID_OP_ANDF)) &&
                        s_q.ir[abid_pkg::DEST_BIT]);

  assign alu_bus.op    = s_q.op;
  assign alu_bus.acc   = s_q.acc;
  assign alu_bus.opnd  = s_q.opnd;
  assign alu_bus.lit   = s_q.ir[7:0];
  assign alu_bus.bpos  = s_q.ir[abid_pkg::BPOS_LSB+2:abid_pkg::BPOS_LSB];
  assign alu_bus.st_in = s_q.st;

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  logic [4:0] alu_st;
  always_comb begin
    s_d    = s_q;
    s_d.rd = 1'b0;
    s_d.wr = 1'b0;
    alu_st = alu_bus.st_out;
    case (s_q.ph)
      abid_pkg::ABID_Q1: begin
        s_d.ph = abid_pkg::ABID_Q2;
        if (!s_q.nop_cyc) begin
          // decode the prefetched word
          s_d.ir      = instr_i;
          s_d.op      = dec_op;
          s_d.illegal = (dec_op == abid_pkg::ABID_OP_NONE);
          s_d.fa      = dec_fa;
          s_d.take    = 1'b0;
          s_d.pc      = s_q.pc + abid_pkg::PC_STEP;
          s_d.rd      = (dec_op == abid_pkg::ABID_OP_ADDC) || (dec_op == abid_pkg::ABID_OP_ANDF) ||
                        (dec_op == abid_pkg::ABID_OP_BCLR);
        end
      end
      abid_pkg::ABID_Q2: begin
        s_d.ph = abid_pkg::ABID_Q3;
        if (!s_q.nop_cyc) begin
          s_d.opnd = file_rdata_i;
        end
      end
      abid_pkg::ABID_Q3: begin
        s_d.ph = abid_pkg::ABID_Q4;
        if (!s_q.nop_cyc) begin
          s_d.res  = alu_bus.res;
          s_d.take = is_branch && cond;
          if (!is_branch) begin
            s_d.st = alu_st;
          end
        end
      end
      default: begin
        s_d.ph = abid_pkg::ABID_Q1;
        if (s_q.nop_cyc) begin
          s_d.nop_cyc = 1'b0;
        end else begin
          if (s_q.take) begin
            // second cycle is all no-op and the prefetch is dropped
            s_d.pc      = target;
            s_d.nop_cyc = 1'b1;
          end else if (writes_file) begin
            s_d.wr = 1'b1;
            s_d.wd = s_q.res;
          end else if ((s_q.op == abid_pkg::ABID_OP_ADDC) || (s_q.op == abid_pkg::ABID_OP_ANDF) ||
                       (s_q.op == abid_pkg::ABID_OP_ANDK)) begin
            s_d.acc = s_q.res;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '{ph: abid_pkg::ABID_Q1, op: abid_pkg::ABID_OP_NONE, nop_cyc: 1'b0, take: 1'b0,
               ir: 16'h0000, opnd: 8'h00, res: 8'h00, st: abid_pkg::STATUS_RST,
               acc: abid_pkg::ACC_RST, pc: abid_pkg::PC_RST, fa: 12'h000, rd: 1'b0,
               wr: 1'b0, wd: 8'h00, illegal: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pc_o         = s_q.pc;
  // fetch in every Q4; a word fetched during a taken branch is dropped by the flush
  assign fetch_o      = (s_q.ph == abid_pkg::ABID_Q4);
  assign file_addr_o  = s_q.fa;
  assign file_rd_o    = s_q.rd;
  assign file_wr_o    = s_q.wr;
  assign file_wdata_o = s_q.wd;
  assign acc_o        = s_q.acc;
  assign status_o     = s_q.st;
  assign phase_o      = s_q.ph;
  assign flush_o      = s_q.nop_cyc;
  assign illegal_o    = s_q.illegal;

endmodule

// ### test/abid_core_asserts.sv
// concurrent checks on the ports of the decode and execute core
`timescale 1ns/1ps
module abid_core_asserts (
  input wire logic                      ref_clk_i,
  input wire logic                      rstn_i,
  input wire logic [abid_pkg::PC_W-1:0] pc_o,
  input wire logic                      file_rd_o,
  input wire logic                      file_wr_o,
  input wire logic [7:0]                acc_o,
  input wire logic [1:0]                phase_o,
  input wire logic                      flush_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_phase_seq;
    phase_o == 2'b00 |=> phase_o == 2'b01 ##1 phase_o == 2'b11 ##1 phase_o == 2'b10;
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("phase order broken");
  property p_rd_q2;
    file_rd_o |-> phase_o == 2'b01;
  endproperty
  a_rd_q2: assert property (p_rd_q2) else $error("operand read outside second phase");
  property p_wr_q1;
    file_wr_o |-> phase_o == 2'b00 && !flush_o;
  endproperty
  a_wr_q1: assert property (p_wr_q1) else $error("file write misplaced");
  property p_flush_len;
    $rose(flush_o) |-> phase_o == 2'b00 ##0 flush_o [*4] ##1 !flush_o;
  endproperty
  a_flush_len: assert property (p_flush_len) else $error("idle cycle not four clocks");
  property p_flush_quiet;
    flush_o |-> !file_rd_o && !file_wr_o;
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("memory access in idle cycle");
  property p_pc_step;
    phase_o == 2'b00 && !flush_o |=> pc_o == $past(pc_o) + 21'h000002;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter did not step by two");
  property p_pc_hold;
    phase_o == 2'b11 || phase_o == 2'b10 |-> $stable(pc_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("counter moved mid cycle");
  property p_acc_hold;
    phase_o != 2'b00 |-> $stable(acc_o);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved before fourth phase");
endmodule
bind abid_core abid_core_asserts u_abid_core_asserts (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pc_o(pc_o),
  .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .acc_o(acc_o), .phase_o(phase_o), .flush_o(flush_o));

// ### test/abid_file_model.sv
// data memory file answering operand reads and write-backs
`timescale 1ns/1ps
module abid_file_model (
  input  wire logic                      ref_clk_i,
  input  wire logic [abid_pkg::FA_W-1:0] file_addr_i,
  input  wire logic                      file_rd_i,
  input  wire logic                      file_wr_i,
  input  wire logic [7:0]                file_wdata_i,
  output logic      [7:0]                file_rdata_o
);
  logic [7:0] mem [4096];
  logic       rd_q;
  logic [7:0] last_q;
  initial begin
    rd_q = 1'b0;
    last_q = 8'h00;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37);
  end
  // outside the read window the lines toggle, so stale data cannot pass
  assign file_rdata_o = (file_rd_i | rd_q) ? mem[file_addr_i] : ~last_q;
  always @(posedge ref_clk_i) begin
    rd_q <= file_rd_i;
    last_q <= file_rdata_o;
    if (file_wr_i) mem[file_addr_i] <= file_wdata_i;
  end
endmodule

// ### test/tb_alu_and_branch_instr_decode.sv
// self-checking bench for the decode and execute core
`timescale 1ns/1ps
module tb_alu_and_branch_instr_decode;
  logic        ref_clk_i, rstn_i, ext_set_en_i, file_rd_o, file_wr_o, fetch_o, flush_o, illegal_o;
  logic [15:0] instr_i;
  logic [3:0]  bank_sel_i;
  logic [20:0] idx_base_i, pc_o, e_pc, pa;
  logic [7:0]  file_rdata_i, file_wdata_o, acc_o, e_acc, e_res, op;
  logic [11:0] file_addr_o, e_addr;
  logic [4:0]  status_o, e_st;
  logic [1:0]  phase_o;
  logic [8:0]  sum;
  logic [4:0]  dc;
  logic        e_wr, e_tk, pend, e_ill;
  int          fails, checked, seed;
  logic [31:0] tbl [8] = '{32'hFC002000, 32'hFC001400, 32'hFF000B00, 32'hF0009000,
                           32'hFF00E200, 32'hFF00E300, 32'hFF00E600, 32'hFF00E700};
  logic [15:0] corner [10] = '{16'h205F, 16'h2060, 16'h0B5F, 16'h1701, 16'h9E05,
                               16'hE27F, 16'hE380, 16'hE6FF, 16'hE700, 16'hFFFF};
  abid_core u_abid_core (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .instr_i(instr_i), .ext_set_en_i(ext_set_en_i),
    .bank_sel_i(bank_sel_i), .idx_base_i(idx_base_i), .file_rdata_i(file_rdata_i), .pc_o(pc_o), .fetch_o(fetch_o),
    .file_addr_o(file_addr_o), .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .file_wdata_o(file_wdata_o),
    .acc_o(acc_o), .status_o(status_o), .phase_o(phase_o), .flush_o(flush_o), .illegal_o(illegal_o));
  abid_file_model u_abid_file_model (.ref_clk_i(ref_clk_i), .file_addr_i(file_addr_o), .file_rd_i(file_rd_o),
    .file_wr_i(file_wr_o), .file_wdata_i(file_wdata_o), .file_rdata_o(file_rdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [11:0] f_addr(logic [15:0] w, logic ext, logic [3:0] bk, logic [20:0] base);
    if (!w[8] && ext && w[7:0] <= 8'h5F) return 12'(base + 21'(w[7:0]));
    if (!w[8]) return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
    return {bk, w[7:0]};
  endfunction
  task automatic chk(input logic ok, input string what);
    checked++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic exec(input logic [15:0] w, input logic ext, input logic [3:0] bk);
    logic [20:0] base;
    base = 21'($random(seed));
    @(posedge ref_clk_i);
    instr_i <= w;
    ext_set_en_i <= ext;
    bank_sel_i <= bk;
    idx_base_i <= base;
    @(negedge ref_clk_i);
    if (pend) begin
      chk(acc_o === e_acc, "accumulator");
      chk(status_o === e_st, "flags");
      chk(pc_o === e_pc, "program counter");
      chk(flush_o === e_tk, "idle cycle");
      chk(file_wr_o === e_wr, "write strobe");
      if (e_wr) chk({file_addr_o, file_wdata_o} === {e_addr, e_res}, "write back");
    end
    while (flush_o === 1'b1) @(negedge ref_clk_i);
    pa = pc_o;
    @(negedge ref_clk_i);
    e_addr = f_addr(w, ext, bk, base);
    op = u_abid_file_model.mem[e_addr];
    e_wr = 1'b0;
    e_tk = 1'b0;
    e_pc = pa + 21'h000002;
    e_res = e_acc & op;
    e_ill = !(w[15:10] == abid_pkg::OPC_ADDC_HI || w[15:10] == abid_pkg::OPC_ANDF_HI ||
              w[15:8] == abid_pkg::OPC_ANDK_HI || w[15:12] == abid_pkg::OPC_BCLR_HI ||
              w[15:8] == abid_pkg::OPC_BRC_HI || w[15:8] == abid_pkg::OPC_BRNC_HI ||
              w[15:8] == abid_pkg::OPC_BRN_HI || w[15:8] == abid_pkg::OPC_BRNN_HI);
    if (w[15:10] == abid_pkg::OPC_ADDC_HI) begin
      sum = {1'b0, e_acc} + {1'b0, op} + 9'(e_st[0]);
      dc = {1'b0, e_acc[3:0]} + {1'b0, op[3:0]} + 5'(e_st[0]);
      e_res = sum[7:0];
      e_st = {sum[7], e_acc[7] == op[7] && sum[7] != e_acc[7], sum[7:0] == 8'h00, dc[4], sum[8]};
    end else if (w[15:12] == abid_pkg::OPC_BCLR_HI) begin
      e_res = op & ~(8'h01 << w[11:9]);
      e_wr = 1'b1;
    end else if (w[15:8] == abid_pkg::OPC_ANDK_HI || w[15:10] == abid_pkg::OPC_ANDF_HI) begin
      if (w[15:8] == abid_pkg::OPC_ANDK_HI) e_res = e_acc & w[7:0];
      e_st = {e_res[7], e_st[3], e_res == 8'h00, e_st[1:0]};
    end else if (!e_ill && w[15:12] == 4'hE) begin
      case (w[11:8])
        4'h2: e_tk = e_st[0];
        4'h3: e_tk = !e_st[0];
        4'h6: e_tk = e_st[4];
        default: e_tk = !e_st[4];
      endcase
      if (e_tk) e_pc = pa + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0};
    end
    if (w[15:10] == abid_pkg::OPC_ADDC_HI || w[15:10] == abid_pkg::OPC_ANDF_HI) begin
      if (w[9]) e_wr = 1'b1;
      else e_acc = e_res;
    end else if (w[15:8] == abid_pkg::OPC_ANDK_HI) e_acc = e_res;
    pend = 1'b1;
    chk(illegal_o === e_ill && fetch_o === 1'b0, "decode flags");
    repeat (2) @(negedge ref_clk_i);
    chk(fetch_o === 1'b1, "fetch strobe");
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r;
    seed = 77;
    {rstn_i, ext_set_en_i, instr_i, bank_sel_i, idx_base_i, pend, e_acc, e_st} = '0;
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({pc_o, acc_o, status_o, phase_o, flush_o, file_wr_o} === 38'h0, "reset state");
    do @(negedge ref_clk_i); while (phase_o !== 2'b10);
    foreach (corner[i]) exec(corner[i], 1'b1, 4'h3);
    repeat (300) begin
      r = $random(seed);
      op = 8'($unsigned($random(seed)) % 8);
      exec((r[15:0] & ~tbl[op][31:16]) | tbl[op][15:0], r[16], r[20:17]);
    end
    exec(16'hFFFF, 1'b0, 4'h0);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk({acc_o, status_o, pc_o, flush_o, file_wr_o} === {e_acc, e_st, e_pc, 2'b00}, "idle word");
    tally_and_finish();
  end
endmodule
